// *** rtl/iso_rate_feedback_defs.vh ***
// constants for the isochronous rate feedback block
// assumes inclusion by bare name from rtl files
`ifndef ISO_RATE_FEEDBACK_DEFS_VH
`define ISO_RATE_FEEDBACK_DEFS_VH

`define RES_BITS_FS 4'hA
`define RES_BITS_HS 4'hD
`define CNT_W 25
`define FRAME_W 13
`define INT_W 12
`define FS_LEFT_SHIFT 4
`define HS_LEFT_SHIFT 3
`define FS_REPORT_LEN 3'h3
`define HS_REPORT_LEN 3'h4
`define ZERO_REPORT_LEN 3'h0
`define FS_UNIFY_SHIFT 2
`define FIFO_DEPTH 16
`define FIFO_ADDR_W 4
`define OWED_W 4
`define TRIM_W 8

`endif

// *** rtl/iso_rate_feedback_logic.v ***
// rate feedback for isochronous endpoints: sink measurement and source accumulator
// assumes sof_in, polls and rate loads come from logic on clk_in; master clock is a pin
// What this block does
// - sink measures rate against frames, sub-hertz resolution
// - resolution ten full speed, thirteen high speed
// - divider shift count limited to resolution range
// - count master clock over window, load, clear
// - never drop a master clock edge
// - source adds rate to fraction each frame, except frames beyond fifteen owed while the fifo is full
// - fraction keeps at least resolution bits
// - full speed 10.10 left-justified into 24 bits
// - full speed low four bits report zero
// - high speed 12.13 placed as 16.16
// - high speed top four, low three zero
// - integer part covers largest per-frame count
// - unimplemented bits of value read zero
// - new value at most once per window
// - unchanged value: current or zero length
// - sink may nudge value for slips
// - prefer shift count between zero and resolution
// - feedback endpoint may be switched off
// - adaptive source may follow sink's observed rate
`default_nettype none
`include "iso_rate_feedback_defs.vh"

module iso_rate_feedback_logic (
  input wire clk_in,
  input wire reset_n_in,
  input wire high_speed_in,
  input wire [3:0] shift_count_in,
  input wire sof_in,
  input wire mclk_pin_in,
  input wire [7:0] rate_trim_in,
  input wire feedback_enable_in,
  input wire zero_len_unchanged_in,
  input wire poll_in,
  output reg fb_valid_out,
  output reg [2:0] fb_len_out,
  output reg [31:0] fb_data_out,
  output reg [24:0] rate_value_out,
  output reg rate_update_out,
  input wire rx_rate_load_in,
  input wire [31:0] rx_rate_in,
  input wire implicit_mode_in,
  output wire count_valid_out,
  input wire count_ready_in,
  output wire [11:0] count_data_out
);
  // master clock pin synchroniser and edge detect
  reg mclk_meta_r;
  reg mclk_sync_r;
  reg mclk_prev_r;
  wire mclk_edge;

  // sink measurement state
  reg started_r;
  reg [`FRAME_W-1:0] frame_cnt_r;
  reg [`FRAME_W-1:0] frame_cnt_nxt;
  reg [`CNT_W-1:0] cycle_cnt_r;
  reg [`CNT_W-1:0] cycle_cnt_nxt;
  reg [`CNT_W-1:0] rate_nxt;
  reg load_nxt;
  reg changed_r;

  // resolution and window length
  wire [3:0] res_bits;
  wire [3:0] shift_eff;
  wire [3:0] win_bits;
  wire [`FRAME_W-1:0] win_last;
  wire win_end;

  // reported value after trim and formatting
  reg [`CNT_W-1:0] trimmed;
  reg [31:0] fb_fmt;
  wire [`CNT_W+1:0] trim_sum;

  // source accumulator
  reg [31:0] rx_rate_r;
  reg [15:0] frac_r;
  reg [`OWED_W-1:0] owed_r;
  reg [`OWED_W-1:0] owed_nxt;
  reg [31:0] rate_unified;
  wire [32:0] acc_sum;
  wire push_req;
  wire fifo_ready;
  wire push;
  wire [`INT_W-1:0] frame_samples;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mclk_meta_r <= 1'b0;
      mclk_sync_r <= 1'b0;
      mclk_prev_r <= 1'b0;
    end else begin
      mclk_meta_r <= mclk_pin_in;
      mclk_sync_r <= mclk_meta_r;
      mclk_prev_r <= mclk_sync_r;
    end
  end

  assign mclk_edge = mclk_sync_r & ~mclk_prev_r;

  assign res_bits = high_speed_in ? `RES_BITS_HS : `RES_BITS_FS;
  // shift count above resolution is clamped to one frame per window
  assign shift_eff = (shift_count_in > res_bits) ? res_bits : shift_count_in;
  assign win_bits = res_bits - shift_eff;
  assign win_last = (({{(`FRAME_W-1){1'b0}}, 1'b1}) << win_bits) - 1'b1;
  // a window shortened mid-count ends at the next frame token instead of running to wrap
  assign win_end = sof_in & started_r & (frame_cnt_r >= win_last);

  always @* begin
    frame_cnt_nxt = frame_cnt_r;
    cycle_cnt_nxt = cycle_cnt_r;
    rate_nxt = rate_value_out;
    load_nxt = 1'b0;
    if (started_r) begin
      cycle_cnt_nxt = cycle_cnt_r + {{(`CNT_W-1){1'b0}}, mclk_edge};
    end
    if (sof_in) begin
      if (!started_r) begin
        frame_cnt_nxt = {`FRAME_W{1'b0}};
        cycle_cnt_nxt = {{(`CNT_W-1){1'b0}}, mclk_edge};
      end else if (win_end) begin
        frame_cnt_nxt = {`FRAME_W{1'b0}};
        // the edge seen at the boundary opens the next window
        rate_nxt = cycle_cnt_r;
        cycle_cnt_nxt = {{(`CNT_W-1){1'b0}}, mclk_edge};
        load_nxt = 1'b1;
      end else begin
        frame_cnt_nxt = frame_cnt_r + 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      started_r <= 1'b0;
      frame_cnt_r <= {`FRAME_W{1'b0}};
      cycle_cnt_r <= {`CNT_W{1'b0}};
      rate_value_out <= {`CNT_W{1'b0}};
      rate_update_out <= 1'b0;
    end else begin
      if (sof_in) begin
        started_r <= 1'b1;
      end
      frame_cnt_r <= frame_cnt_nxt;
      cycle_cnt_r <= cycle_cnt_nxt;
      rate_value_out <= rate_nxt;
      rate_update_out <= load_nxt;
    end
  end

  // signed nudge added to the measured value, clamped at zero and full scale
  assign trim_sum = {2'b00, rate_value_out} + {{(`CNT_W-6){rate_trim_in[7]}}, rate_trim_in};

  always @* begin
    trimmed = trim_sum[`CNT_W-1:0];
    if (trim_sum[`CNT_W+1]) begin
      trimmed = {`CNT_W{1'b0}};
    end else if (trim_sum[`CNT_W]) begin
      trimmed = {`CNT_W{1'b1}};
    end
    fb_fmt = 32'h00000000;
    if (high_speed_in) begin
      // 12.13 placed at 16.16: top four and low three stay zero
      fb_fmt = {4'h0, trimmed, 3'h0};
    end else begin
      // 10.10 left-justified in 24 bits: low four stay zero
      fb_fmt = {8'h00, trimmed[19:0], 4'h0};
    end
  end

  // report path: one answer per poll, next cycle
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fb_valid_out <= 1'b0;
      fb_len_out <= `ZERO_REPORT_LEN;
      fb_data_out <= 32'h00000000;
      changed_r <= 1'b0;
    end else begin
      fb_valid_out <= 1'b0;
      if (poll_in && feedback_enable_in) begin
        fb_valid_out <= 1'b1;
        if (zero_len_unchanged_in && !changed_r) begin
          fb_len_out <= `ZERO_REPORT_LEN;
          fb_data_out <= 32'h00000000;
        end else begin
          fb_len_out <= high_speed_in ? `HS_REPORT_LEN : `FS_REPORT_LEN;
          fb_data_out <= fb_fmt;
        end
      end
      // a load of a changed value in the poll cycle keeps the flag set
      if (load_nxt && rate_nxt != rate_value_out) begin
        changed_r <= 1'b1;
      end else if (poll_in && feedback_enable_in) begin
        changed_r <= 1'b0;
      end
    end
  end

  // adaptive source: received or observed rate, unified to 16.16
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_rate_r <= 32'h00000000;
    end else if (rx_rate_load_in) begin
      rx_rate_r <= rx_rate_in;
    end
  end

  always @* begin
    rate_unified = 32'h00000000;
    if (implicit_mode_in) begin
      // follow the rate observed on the sink side
      rate_unified = high_speed_in ? {4'h0, rate_value_out, 3'h0} : {6'h00, rate_value_out[19:0], 6'h00};
    end else if (high_speed_in) begin
      rate_unified = rx_rate_r;
    end else begin
      rate_unified = {6'h00, rx_rate_r[23:0], 2'h0};
    end
  end

  assign acc_sum = {{17{1'b0}}, frac_r} + {1'b0, rate_unified};
  assign frame_samples = acc_sum[16+`INT_W-1:16];
  assign push_req = sof_in | (owed_r != {`OWED_W{1'b0}});
  assign push = push_req & fifo_ready;

  // frames not yet accumulated while the fifo is full
  always @* begin
    owed_nxt = owed_r;
    if (sof_in && !push && owed_r != {`OWED_W{1'b1}}) begin
      owed_nxt = owed_r + 1'b1;
    end else if (!sof_in && push) begin
      owed_nxt = owed_r - 1'b1;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frac_r <= 16'h0000;
      owed_r <= {`OWED_W{1'b0}};
    end else begin
      owed_r <= owed_nxt;
      if (push) begin
        frac_r <= acc_sum[15:0];
      end
    end
  end

  rate_sample_fifo #(
    .WIDTH(`INT_W),
    .DEPTH(`FIFO_DEPTH),
    .ADDR_W(`FIFO_ADDR_W)
  ) u_sample_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(push_req),
    .in_ready_out(fifo_ready),
    .in_data_in(frame_samples),
    .out_valid_out(count_valid_out),
    .out_ready_in(count_ready_in),
    .out_data_out(count_data_out)
  );
endmodule // iso_rate_feedback_logic

`default_nettype wire

// *** rtl/rate_sample_fifo.v ***
// flop-based fifo with valid/ready on both sides
// assumes a single clock and an active-low asynchronous reset
`default_nettype none

module rate_sample_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter ADDR_W = 4
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [ADDR_W-1:0] wr_ptr_r;
  reg [ADDR_W-1:0] rd_ptr_r;
  reg [ADDR_W:0] fill_r;
  wire [WIDTH-1:0] entry_q [0:DEPTH-1];
  wire push;
  wire pop;

  assign in_ready_out = (fill_r != DEPTH[ADDR_W:0]);
  assign out_valid_out = (fill_r != {(ADDR_W+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = entry_q[rd_ptr_r];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam integer SLOT = i;
      reg [WIDTH-1:0] word_r;
      always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          word_r <= {WIDTH{1'b0}};
        end else if (push && wr_ptr_r == SLOT[ADDR_W-1:0]) begin
          word_r <= in_data_in;
        end
      end
      assign entry_q[i] = word_r;
    end
  endgenerate

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      rd_ptr_r <= {ADDR_W{1'b0}};
      fill_r <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        fill_r <= fill_r + 1'b1;
      end else if (pop && !push) begin
        fill_r <= fill_r - 1'b1;
      end
    end
  end
endmodule // rate_sample_fifo

`default_nettype wire

// *** tb/host_side_model.sv ***
// far side model: frame tokens, feedback polls, master clock
// assumes the bench's 10 ns clock; frame is 64 cycles
`default_nettype none
module host_side_model (
  input wire logic clk_in,
  input wire logic poll_en_in,
  output logic sof_out,
  output logic poll_out,
  output logic mclk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  initial begin
    sof_out = 1'b0;
    poll_out = 1'b0;
    mclk_out = 1'b0;
  end
  always @(posedge clk_in) begin
    #1;
    cyc = (cyc + 1) % 64;
    sof_out = (cyc == 0);
    poll_out = poll_en_in && (cyc == 20);
    // master clock at one eighth of the system clock
    mclk_out = cyc[2];
  end
endmodule // host_side_model
`default_nettype wire

// *** tb/iso_rate_feedback_logic_test.sv ***
// self-checking bench for iso_rate_feedback_logic
// assumes host_side_model and the fifo are compiled alongside
`default_nettype none
module iso_rate_feedback_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, reset_n_in = 0, hs = 0, sof_in, mclk_pin_in, fb_en = 1, zl = 0, poll_in, load = 0;
  logic ready = 0, poll_en = 0, checking = 0, stall = 0, imp = 0;
  logic [3:0] shift = 4'hA;
  logic [7:0] trim = 8'h00;
  logic [31:0] rx = 32'h0, seed = 32'h5FA7;
  wire fb_valid_out, rate_update_out, count_valid_out;
  wire [2:0] fb_len_out;
  wire [31:0] fb_data_out;
  wire [24:0] rate_value_out;
  wire [11:0] count_data_out;
  int error_cnt = 0, samples_checked = 0, cycles = 0, win = 1, last_ans = -1, val, rate = 0, frac = 0, acc;
  int q[$];
  int sh[5] = '{10, 9, 13, 11, 15};
  int wn[5] = '{1, 2, 1, 4, 1};
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #5 clk_in = ~clk_in;
  host_side_model host_u (.clk_in(clk_in), .poll_en_in(poll_en), .sof_out(sof_in), .poll_out(poll_in),
    .mclk_out(mclk_pin_in));
  iso_rate_feedback_logic dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .high_speed_in(hs), .shift_count_in(shift),
    .sof_in(sof_in), .mclk_pin_in(mclk_pin_in), .rate_trim_in(trim), .feedback_enable_in(fb_en),
    .zero_len_unchanged_in(zl), .poll_in(poll_in), .fb_valid_out(fb_valid_out), .fb_len_out(fb_len_out),
    .fb_data_out(fb_data_out), .rate_value_out(rate_value_out), .rate_update_out(rate_update_out),
    .rx_rate_load_in(load), .rx_rate_in(rx), .implicit_mode_in(imp), .count_valid_out(count_valid_out),
    .count_ready_in(ready), .count_data_out(count_data_out));
  // consumer side: random ready unless stalled
  always @(posedge clk_in) begin
    #1;
    ready = !stall && seed[0];
    seed = xs(seed);
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
    if (reset_n_in && sof_in) begin
      // implicit mode follows the steady measured count, unified to 16.16
      acc = frac + (imp ? (8 * win) << (hs ? 3 : 6) : rate);
      q.push_back(acc[27:16]);
      frac = acc & 32'hFFFF;
    end
    if (load) rate = hs ? rx : {rx[23:0], 2'b00};
    if (count_valid_out && ready) check(count_data_out, q.pop_front());
    val = 8 * win + $signed(trim);
    if (val < 0) val = 0;
    if (checking && rate_update_out) check(rate_value_out, 8 * win);
    if (checking && fb_valid_out) begin
      // unchanged means the measured count, before the nudge
      if (zl && 8 * win == last_ans) begin
        check(fb_len_out, 0);
        check(fb_data_out, 0);
      end else begin
        check(fb_len_out, hs ? 4 : 3);
        check(fb_data_out, hs ? {4'h0, val[24:0], 3'h0} : {8'h0, val[19:0], 4'h0});
      end
      last_ans = 8 * win;
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    #1 reset_n_in = 1;
    for (int i = 0; i < 5; i++) begin
      @(posedge sof_in);
      repeat (3) @(posedge clk_in);
      #1 checking = 0;
      poll_en = 0;
      imp = 0;
      hs = (i == 2 || i == 3);
      shift = sh[i][3:0];
      win = wn[i];
      zl = (i == 1);
      fb_en = (i != 4);
      trim = seed[7:0];
      rx = {5'h0, seed[26:0]};
      load = 1;
      // fifo fills until refused in the long window
      stall = (i == 3);
      @(posedge clk_in);
      #1 load = 0;
      repeat ((3 * wn[i] + 6) * 64) @(posedge clk_in);
      #1 stall = 0;
      checking = 1;
      poll_en = 1;
      // observed rate as feedback once the measurement has settled
      imp = (i == 0 || i == 4);
      repeat ((2 * wn[i] + 2) * 64) @(posedge clk_in);
    end
    close_out();
  end
endmodule // iso_rate_feedback_logic_test
`default_nettype wire

// *** tb/rate_fb_asserts.sv ***
// checker for the rate feedback block ports
// assumes binding onto iso_rate_feedback_logic
`default_nettype none
module rate_fb_asserts (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sof_in,
  input wire logic feedback_enable_in,
  input wire logic poll_in,
  input wire logic fb_valid_out,
  input wire logic [2:0] fb_len_out,
  input wire logic [31:0] fb_data_out,
  input wire logic [24:0] rate_value_out,
  input wire logic rate_update_out,
  input wire logic count_valid_out,
  input wire logic count_ready_in,
  input wire logic [11:0] count_data_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_ans; poll_in && feedback_enable_in |=> fb_valid_out; endproperty
  a_ans: assert property (p_ans) else $error("poll not answered");
  property p_noans; !(poll_in && feedback_enable_in) |=> !fb_valid_out; endproperty
  a_noans: assert property (p_noans) else $error("answer without poll");
  property p_upd; rate_update_out |-> $past(sof_in) && !$past(rate_update_out); endproperty
  a_upd: assert property (p_upd) else $error("update not after frame token");
  property p_hold; $changed(rate_value_out) |-> rate_update_out; endproperty
  a_hold: assert property (p_hold) else $error("value moved off window end");
  property p_fs; fb_valid_out && fb_len_out == 3'h3 |-> fb_data_out[31:24] == 8'h0 && fb_data_out[3:0] == 4'h0;
  endproperty
  a_fs: assert property (p_fs) else $error("full speed layout bits");
  property p_hs; fb_valid_out && fb_len_out == 3'h4 |-> fb_data_out[31:28] == 4'h0 && fb_data_out[2:0] == 3'h0;
  endproperty
  a_hs: assert property (p_hs) else $error("high speed layout bits");
  property p_zl; fb_valid_out && fb_len_out == 3'h0 |-> fb_data_out == 32'h0; endproperty
  a_zl: assert property (p_zl) else $error("zero length with data");
  property p_cnt; count_valid_out && !count_ready_in |=> count_valid_out && $stable(count_data_out); endproperty
  a_cnt: assert property (p_cnt) else $error("count head dropped");
endmodule // rate_fb_asserts
bind iso_rate_feedback_logic rate_fb_asserts chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .sof_in(sof_in),
  .feedback_enable_in(feedback_enable_in), .poll_in(poll_in), .fb_valid_out(fb_valid_out), .fb_len_out(fb_len_out),
  .fb_data_out(fb_data_out), .rate_value_out(rate_value_out), .rate_update_out(rate_update_out),
  .count_valid_out(count_valid_out), .count_ready_in(count_ready_in), .count_data_out(count_data_out));
`default_nettype wire
